// ### hw/ufs_pkg.sv
// package: register map, field layout and reset values of the uart fifo shadow block
package ufs_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] UFS_OFS_DMA_MODE = 32'h5000_1194;
    localparam logic [31:0] UFS_OFS_FIFO_ON = 32'h5000_1198;
    localparam logic [31:0] UFS_OFS_RX_TRIG = 32'h5000_119c;
    localparam logic [31:0] UFS_OFS_TX_TRIG = 32'h5000_11a0;
    localparam logic [31:0] UFS_OFS_FCW = 32'h5000_11b0;
    localparam logic [31:0] UFS_OFS_IRQ_STAT = 32'h5000_11b4;
    localparam logic [31:0] UFS_OFS_IRQ_MASK = 32'h5000_11b8;
    // ------------------------------------------------------------
    // fifo_control_word fields
    // ------------------------------------------------------------
    localparam int UFS_FCW_FIFO_ON = 0;
    localparam int UFS_FCW_RX_RST = 1;
    localparam int UFS_FCW_TX_RST = 2;
    localparam int UFS_FCW_DMA = 3;
    localparam int UFS_FCW_TXT_LO = 4;
    localparam int UFS_FCW_RXT_LO = 6;
    localparam logic [7:0] UFS_FCW_RESET = 8'h00;
    // self-clearing reset bits never stay set in the stored word
    localparam logic [7:0] UFS_FCW_STORE_MASK = 8'hf9;
    // ------------------------------------------------------------
    // interrupt status / mask bits
    // ------------------------------------------------------------
    localparam int UFS_IRQ_W = 3;
    localparam int UFS_IRQ_RX_TRIG = 0;
    localparam int UFS_IRQ_TX_LOW = 1;
    localparam int UFS_IRQ_FIFO_RST = 2;
    localparam logic [2:0] UFS_IRQ_RESET = 3'h0;
    // ------------------------------------------------------------
    // trigger codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UFS_RXT_ONE = 2'b00,
        UFS_RXT_HALF_A = 2'b01,
        UFS_RXT_HALF_B = 2'b10,
        UFS_RXT_TWO_LESS = 2'b11
    } ufs_rx_trig_t;
    typedef enum logic [1:0] {
        UFS_TXT_EMPTY = 2'b00,
        UFS_TXT_TWO = 2'b01,
        UFS_TXT_HALF = 2'b10,
        UFS_TXT_QUARTER = 2'b11
    } ufs_tx_trig_t;
endpackage

// ### hw/ufs_shadow.sv
// module: fifo control shadow registers with wishbone slave, dma requests and interrupt
//
// Design decision made here: the Wishbone register port.
module ufs_shadow
    import ufs_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [LW-1:0] rx_level_i,
    input wire logic [LW-1:0] tx_level_i,
    input wire logic tx_low_mode_i,
    output logic fifo_on_o,
    output logic dma_mode_o,
    output logic [1:0] rx_trig_o,
    output logic [1:0] tx_trig_o,
    output logic receive_queue_reset_o,
    output logic transmit_queue_reset_o,
    output logic rx_data_avail_o,
    output logic tx_holding_empty_irq_o,
    output logic rx_dma_req_n_o,
    output logic tx_dma_req_n_o,
    output logic irq_o
);
    import ufs_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic ack_q;
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire hit_dma = wb_adr_i == UFS_OFS_DMA_MODE;
    wire hit_on = wb_adr_i == UFS_OFS_FIFO_ON;
    wire hit_rxt = wb_adr_i == UFS_OFS_RX_TRIG;
    wire hit_txt = wb_adr_i == UFS_OFS_TX_TRIG;
    wire hit_fcw = wb_adr_i == UFS_OFS_FCW;
    wire hit_stat = wb_adr_i == UFS_OFS_IRQ_STAT;
    wire hit_mask = wb_adr_i == UFS_OFS_IRQ_MASK;

    // ------------------------------------------------------------
    // fifo control word
    // ------------------------------------------------------------
    logic [7:0] fcw_q;
    logic [7:0] fcw_d;
    always_comb begin
        fcw_d = fcw_q;
        if (wr && hit_dma) begin
            fcw_d[UFS_FCW_DMA] = wb_dat_i[0];
        end
        if (wr && hit_on) begin
            fcw_d[UFS_FCW_FIFO_ON] = wb_dat_i[0];
        end
        if (wr && hit_rxt) begin
            fcw_d[UFS_FCW_RXT_LO +: 2] = wb_dat_i[1:0];
        end
        if (wr && hit_txt) begin
            fcw_d[UFS_FCW_TXT_LO +: 2] = wb_dat_i[1:0];
        end
        if (wr && hit_fcw) begin
            fcw_d = wb_dat_i[7:0] & UFS_FCW_STORE_MASK;
        end
    end

    wire fifo_on = fcw_q[UFS_FCW_FIFO_ON];
    wire dma_mode = fcw_q[UFS_FCW_DMA];
    wire [1:0] rxt = fcw_q[UFS_FCW_RXT_LO +: 2];
    wire [1:0] txt = fcw_q[UFS_FCW_TXT_LO +: 2];
    // a falling enable clears both controllers at once
    wire on_fall = fifo_on & ~fcw_d[UFS_FCW_FIFO_ON];
    wire fcw_wr = wr & hit_fcw;
    wire rx_rst_d = on_fall | (fcw_wr & wb_dat_i[UFS_FCW_RX_RST]);
    wire tx_rst_d = on_fall | (fcw_wr & wb_dat_i[UFS_FCW_TX_RST]);

    // ------------------------------------------------------------
    // thresholds
    // ------------------------------------------------------------
    localparam logic [LW-1:0] LV_ONE = LW'(1);
    localparam logic [LW-1:0] LV_TWO = LW'(2);
    localparam logic [LW-1:0] LV_HALF = LW'(DEPTH / 2);
    localparam logic [LW-1:0] LV_QUART = LW'(DEPTH / 4);
    localparam logic [LW-1:0] LV_NFULL = LW'(DEPTH - 2);
    localparam logic [LW-1:0] LV_FULL = LW'(DEPTH);
    localparam logic [LW-1:0] LV_ZERO = LW'(0);

    wire [LW-1:0] rx_thr = (rxt == UFS_RXT_ONE) ? LV_ONE :
        (rxt == UFS_RXT_TWO_LESS) ? LV_NFULL : LV_HALF;
    wire [LW-1:0] tx_thr = (txt == UFS_TXT_EMPTY) ? LV_ZERO :
        (txt == UFS_TXT_TWO) ? LV_TWO :
        (txt == UFS_TXT_HALF) ? LV_HALF : LV_QUART;
    // without fifos a single character is the only meaningful level
    wire rx_hit = fifo_on ? (rx_level_i >= rx_thr) : (rx_level_i >= LV_ONE);
    wire tx_low = (fifo_on && tx_low_mode_i) ? (tx_level_i <= tx_thr) :
        (tx_level_i == LV_ZERO);

    // ------------------------------------------------------------
    // dma request signalling
    // ------------------------------------------------------------
    logic rx_req_q;
    logic tx_req_q;
    logic rx_req_d;
    logic tx_req_d;
    always_comb begin
        rx_req_d = rx_req_q;
        tx_req_d = tx_req_q;
        if (!dma_mode) begin
            rx_req_d = rx_level_i >= LV_ONE;
            tx_req_d = tx_level_i == LV_ZERO;
        end else begin
            // mode 1 holds the request until the queue drains or fills
            if (rx_hit) begin
                rx_req_d = 1'b1;
            end else if (rx_level_i == LV_ZERO) begin
                rx_req_d = 1'b0;
            end
            if (tx_low) begin
                tx_req_d = 1'b1;
            end else if (tx_level_i >= LV_FULL) begin
                tx_req_d = 1'b0;
            end
        end
        if (rx_rst_d) begin
            rx_req_d = 1'b0;
        end
        if (tx_rst_d) begin
            tx_req_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [UFS_IRQ_W-1:0] stat_q;
    logic [UFS_IRQ_W-1:0] mask_q;
    logic rx_hit_q;
    logic tx_low_q;
    wire [UFS_IRQ_W-1:0] ev = {on_fall, tx_low & ~tx_low_q, rx_hit & ~rx_hit_q};
    wire [UFS_IRQ_W-1:0] clr = (wr && hit_stat) ? wb_dat_i[UFS_IRQ_W-1:0] : '0;
    // set beats a simultaneous write-one clear
    wire [UFS_IRQ_W-1:0] stat_d = (stat_q & ~clr) | ev;
    wire [UFS_IRQ_W-1:0] mask_d = (wr && hit_mask) ? wb_dat_i[UFS_IRQ_W-1:0] : mask_q;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] rdata = hit_dma ? {31'h0, dma_mode} :
        hit_on ? {31'h0, fifo_on} :
        hit_rxt ? {30'h0, rxt} :
        hit_txt ? {30'h0, txt} :
        hit_fcw ? {24'h0, fcw_q} :
        hit_stat ? {29'h0, stat_q} :
        hit_mask ? {29'h0, mask_q} : 32'h0;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
            fcw_q <= UFS_FCW_RESET;
            stat_q <= UFS_IRQ_RESET;
            mask_q <= UFS_IRQ_RESET;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            wb_dat_o <= req ? rdata : 32'h0;
            fcw_q <= fcw_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hit_q <= 1'b0;
            tx_low_q <= 1'b0;
            rx_req_q <= 1'b0;
            tx_req_q <= 1'b0;
            rx_dma_req_n_o <= 1'b1;
            tx_dma_req_n_o <= 1'b1;
            receive_queue_reset_o <= 1'b0;
            transmit_queue_reset_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            rx_hit_q <= rx_hit;
            tx_low_q <= tx_low;
            rx_req_q <= rx_req_d;
            tx_req_q <= tx_req_d;
            // request pins get their own flops so the controller never sees a glitch
            rx_dma_req_n_o <= ~rx_req_d;
            tx_dma_req_n_o <= ~tx_req_d;
            receive_queue_reset_o <= rx_rst_d;
            transmit_queue_reset_o <= tx_rst_d;
            irq_o <= |(stat_d & mask_d);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign fifo_on_o = fcw_q[UFS_FCW_FIFO_ON];
    assign dma_mode_o = fcw_q[UFS_FCW_DMA];
    assign rx_trig_o = fcw_q[UFS_FCW_RXT_LO +: 2];
    assign tx_trig_o = fcw_q[UFS_FCW_TXT_LO +: 2];
    assign rx_data_avail_o = rx_hit_q;
    assign tx_holding_empty_irq_o = tx_low_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_dma_alias: assert property (
        wr && hit_dma |=> dma_mode_o == $past(wb_dat_i[0]))
        else $error("dma mode shadow write not reflected");
    a_on_alias: assert property (
        wr && hit_on |=> fifo_on_o == $past(wb_dat_i[0]))
        else $error("fifo enable shadow write not reflected");
    a_rxt_alias: assert property (
        wr && hit_rxt |=> rx_trig_o == $past(wb_dat_i[1:0]))
        else $error("rx trigger shadow write not reflected");
    a_txt_alias: assert property (
        wr && hit_txt |=> tx_trig_o == $past(wb_dat_i[1:0]))
        else $error("tx trigger shadow write not reflected");
    a_other_fields: assert property (
        wr && hit_dma |=> {fifo_on_o, rx_trig_o, tx_trig_o} ==
            $past({fifo_on_o, rx_trig_o, tx_trig_o}))
        else $error("dma shadow write disturbed other fields");
    a_fall_reset: assert property (
        fifo_on_o && !fcw_d[UFS_FCW_FIFO_ON] |=> receive_queue_reset_o &&
            transmit_queue_reset_o ##1 !receive_queue_reset_o)
        else $error("fifo disable did not pulse both resets");
    a_rx_level: assert property (
        fifo_on && rxt == UFS_RXT_TWO_LESS && rx_level_i == LW'(DEPTH - 3)
            |=> !rx_data_avail_o)
        else $error("rx trigger fired below two-less-than-full");
    a_mode1_req: assert property (
        dma_mode && rx_hit && !rx_rst_d |=> !rx_dma_req_n_o)
        else $error("mode 1 rx request missing at trigger");
    a_mode0_req: assert property (
        !dma_mode && rx_level_i == LV_ZERO && !rx_rst_d |=> rx_dma_req_n_o)
        else $error("mode 0 rx request with empty queue");
    a_tx_thresh: assert property (
        fifo_on && tx_low_mode_i && txt == UFS_TXT_TWO && tx_level_i == LV_TWO
            |=> tx_holding_empty_irq_o)
        else $error("tx threshold two not honoured");
    a_rsvd_read: assert property (
        req && !wb_we_i && (hit_rxt || hit_txt) |=> wb_ack_o && wb_dat_o[31:2] == 30'h0)
        else $error("reserved bits read non-zero");
    a_bus_ack: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (
        req |=> wb_ack_o)
        else $error("taken request not acknowledged");
    a_mode0_tx: assert property (
        !dma_mode && tx_level_i == LV_ZERO && !tx_rst_d |=> !tx_dma_req_n_o)
        else $error("mode 0 tx request missing with empty queue");
    a_off_level: assert property (
        !fifo_on |=> rx_data_avail_o == ($past(rx_level_i) != LV_ZERO))
        else $error("queues off but rx level not single character");
    a_rx_half: assert property (
        fifo_on && (rxt == UFS_RXT_HALF_A || rxt == UFS_RXT_HALF_B)
            |=> rx_data_avail_o == ($past(rx_level_i) >= LV_HALF))
        else $error("rx half trigger not honoured");
    a_mode1_hold: assert property (
        dma_mode && rx_req_q && !rx_hit && rx_level_i != LV_ZERO && !rx_rst_d
            |=> !rx_dma_req_n_o)
        else $error("mode 1 rx request dropped before queue drained");
    a_fcw_rsvd: assert property (
        req && !wb_we_i && hit_fcw |=> wb_dat_o[2:1] == 2'b00)
        else $error("self clearing reset bits read non-zero");
    // ------------------------------------------------------------
    // interrupt checks
    // ------------------------------------------------------------
    a_irq_level: assert property (
        irq_o == |(stat_q & mask_q))
        else $error("irq does not follow masked status");
    a_set_wins: assert property (
        ev[UFS_IRQ_RX_TRIG] |=> stat_q[UFS_IRQ_RX_TRIG])
        else $error("rx trigger event lost against clear");

    c_fifo_off: cover property (fifo_on_o ##1 !fifo_on_o);
    c_mode1_rx: cover property (dma_mode_o && !rx_dma_req_n_o);
    c_irq: cover property (!irq_o ##1 irq_o);
    c_fcw_write: cover property (wr && hit_fcw);
    c_mode1_tx: cover property (dma_mode_o && !tx_dma_req_n_o);
endmodule

// ### test/ufs_dma_model.sv
// dma controller model: services request outputs by draining rx and filling tx
module ufs_dma_model #(
    parameter int DEPTH = 16,
    parameter int LW = 5
) (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic rx_dma_req_n_i,
    input wire logic tx_dma_req_n_i,
    output logic [LW-1:0] rx_level_o,
    output logic [LW-1:0] tx_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_level_o = '0;
        tx_level_o = '0;
    end
    // bench loads levels only while the controller is stalled
    task automatic put(input logic [LW-1:0] r, input logic [LW-1:0] t);
        rx_level_o <= r;
        tx_level_o <= t;
    endtask
    // one word per cycle while requested; never under- or overruns a queue
    always @(posedge clk_i) begin
        if (go_i && !rx_dma_req_n_i && rx_level_o != 0) begin
            rx_level_o <= rx_level_o - 1'b1;
        end
        if (go_i && !tx_dma_req_n_i && tx_level_o < DEPTH) begin
            tx_level_o <= tx_level_o + 1'b1;
        end
    end
endmodule

// ### test/tb.sv
// testbench: shadow fields, queue resets, thresholds, dma handshake, interrupt
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ufs_pkg::*;
    localparam int DEPTH = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic tx_low_mode_i = 1'b0;
    logic go = 1'b0;
    logic [31:0] wb_dat_o, r, fcw;
    logic [4:0] rx_level_i, tx_level_i;
    logic [1:0] rx_trig_o, tx_trig_o;
    logic wb_ack_o, fifo_on_o, dma_mode_o, receive_queue_reset_o, transmit_queue_reset_o;
    logic rx_data_avail_o, tx_holding_empty_irq_o, rx_dma_req_n_o, tx_dma_req_n_o, irq_o;
    int err_count = 0;
    int check_count = 0;
    int pulses = 0;
    int exp_p = 0;
    int k, d, m;
    logic [31:0] adr_t [4] = '{UFS_OFS_DMA_MODE, UFS_OFS_FIFO_ON, UFS_OFS_RX_TRIG, UFS_OFS_TX_TRIG};
    int lsb_t [4] = '{UFS_FCW_DMA, UFS_FCW_FIFO_ON, UFS_FCW_RXT_LO, UFS_FCW_TXT_LO};
    int wid_t [4] = '{1, 1, 2, 2};
    int rxt [4] = '{1, DEPTH / 2, DEPTH / 2, DEPTH - 2};
    int txt [4] = '{0, 2, DEPTH / 2, DEPTH / 4};

    ufs_shadow #(.DEPTH(DEPTH)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_level_i, .tx_level_i,
        .tx_low_mode_i, .fifo_on_o, .dma_mode_o, .rx_trig_o, .tx_trig_o, .receive_queue_reset_o,
        .transmit_queue_reset_o, .rx_data_avail_o, .tx_holding_empty_irq_o, .rx_dma_req_n_o,
        .tx_dma_req_n_o, .irq_o);
    ufs_dma_model #(.DEPTH(DEPTH), .LW(5)) u_dma (.clk_i, .go_i(go),
        .rx_dma_req_n_i(rx_dma_req_n_o), .tx_dma_req_n_i(tx_dma_req_n_o),
        .rx_level_o(rx_level_i), .tx_level_o(tx_level_i));

    always #2.5 clk_i = ~clk_i;
    // both queue controllers must be reset in the same cycle
    always @(posedge clk_i) if (receive_queue_reset_o && transmit_queue_reset_o) pulses++;

    // ------------------------------------------------------------
    // verdict, compare and bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    // idle cycle first so a release is never overwritten in the same step
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] dd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= dd;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("ERROR %0t no ack", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] dd);
        wb(1'b1, a, dd);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
        wb(1'b0, a, 32'h0);
        chk(r, e, s);
    endtask
    // outputs lag the levels by one registered stage
    task automatic lv(input int rr, input int tt);
        u_dma.put(rr[4:0], tt[4:0]);
        repeat (3) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hb0a4ae09));
        fcw = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rd(adr_t[i], 32'h0, "reset value");
        rd(32'h5000_11bc, 32'h0, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            k = i % 4;
            d = $urandom();
            m = (1 << wid_t[k]) - 1;
            if (k == 1 && fcw[0] && !d[0]) exp_p++;
            fcw = (fcw & ~(m << lsb_t[k])) | ((d & m) << lsb_t[k]);
            wr(adr_t[k], d);
            rd(adr_t[k], (fcw >> lsb_t[k]) & m, "shadow read");
            rd(UFS_OFS_FCW, fcw, "control word");
            chk({dma_mode_o, fifo_on_o}, {fcw[3], fcw[0]}, "mode bits");
            chk({rx_trig_o, tx_trig_o}, fcw[7:4], "trigger fields");
        end
        $display("test shadow fields done");
        lv(0, 0);
        wr(UFS_OFS_DMA_MODE, 32'h0);
        wr(UFS_OFS_FIFO_ON, 32'h1);
        wr(UFS_OFS_FIFO_ON, 32'h0);
        exp_p++;
        wr(UFS_OFS_FIFO_ON, 32'h1);
        chk(pulses, exp_p, "queue reset pulses");
        wr(UFS_OFS_FCW, 32'h7);
        exp_p++;
        rd(UFS_OFS_FCW, 32'h1, "reset bits self clear");
        chk(pulses, exp_p, "control word queue resets");
        for (int c = 0; c < 4; c++) begin
            wr(UFS_OFS_RX_TRIG, c);
            lv(rxt[c] - 1, 1);
            chk(rx_data_avail_o, 1'b0, "below rx trigger");
            chk(rx_dma_req_n_o, rxt[c] == 1, "mode 0 rx request");
            lv(rxt[c], 1);
            chk(rx_data_avail_o, 1'b1, "at rx trigger");
        end
        tx_low_mode_i <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(UFS_OFS_TX_TRIG, c);
            lv(0, txt[c]);
            chk(tx_holding_empty_irq_o, 1'b1, "at tx threshold");
            lv(0, txt[c] + 1);
            chk(tx_holding_empty_irq_o, 1'b0, "above tx threshold");
        end
        $display("test thresholds done");
        wr(UFS_OFS_RX_TRIG, 32'h0);
        wr(UFS_OFS_IRQ_STAT, 32'h7);
        wr(UFS_OFS_IRQ_MASK, 32'h1 << UFS_IRQ_RX_TRIG);
        lv(1, 0);
        chk(irq_o, 1'b1, "rx trigger irq");
        wr(UFS_OFS_IRQ_STAT, 32'h7);
        lv(1, 0);
        chk(irq_o, 1'b0, "irq cleared");
        wr(UFS_OFS_IRQ_MASK, 32'h0);
        lv(0, 0);
        lv(1, 0);
        chk(irq_o, 1'b0, "irq masked");
        $display("test interrupt done");
        tx_low_mode_i <= 1'b0;
        lv(0, DEPTH);
        wr(UFS_OFS_DMA_MODE, 32'h1);
        wr(UFS_OFS_RX_TRIG, 32'h3);
        lv(DEPTH - 3, DEPTH);
        chk({rx_dma_req_n_o, tx_dma_req_n_o}, 2'b11, "mode 1 idle");
        lv(DEPTH - 2, 0);
        chk({rx_dma_req_n_o, tx_dma_req_n_o}, 2'b00, "mode 1 request");
        go <= 1'b1;
        repeat (60) @(posedge clk_i);
        go <= 1'b0;
        chk({rx_level_i, tx_level_i}, {5'd0, 5'(DEPTH)}, "queues serviced");
        chk({rx_dma_req_n_o, tx_dma_req_n_o}, 2'b11, "requests dropped");
        $display("test dma done");
        tally_and_finish();
    end
endmodule
